// ===== rtl/pac_clk_div.sv
// divides the accumulator clock by 256 and by 65536
`timescale 1ns/1ps
module pac_clk_div
  import pac_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tickIn,
  output logic      tick256,
  output logic      tick65536
);

  logic [15:0] divCount;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divCount <= COUNT_RESET;
    end else if (tickIn) begin
      divCount <= divCount + COUNT_STEP;
    end
  end

  assign tick256   = tickIn & (divCount[7:0] == DIV_LOW_MAX);
  assign tick65536 = tickIn & (divCount == COUNT_MAX);

endmodule : pac_clk_div

// ===== rtl/pac_ctrl.sv
// pulse accumulator control with axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module pac_ctrl
  import pac_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  channelSevenPin,
  input  wire logic                  timerEnable,
  input  wire logic                  prescalerTick,
  input  wire logic                  div64Tick,
  output logic                       counterTick,
  output logic                       accumulatorClock,
  output logic                       overflowIrq,
  output logic                       inputEdgeIrq
);

  pac_ctrl_t             ctrl;
  pac_flags_t            flags;
  logic [15:0]           accumulatorCount;
  logic                  awHeld;
  logic                  wHeld;
  logic [AXI_ADDR_W-1:0] awAddr;
  logic [AXI_DATA_W-1:0] wData;
  logic [3:0]            wStrb;
  logic                  pinLevel;
  logic                  pinRise;
  logic                  pinFall;
  logic                  tick256;
  logic                  tick65536;

  // ---------------- axi4-lite write path ----------------
  wire                  awFire   = s_axi_awvalid & s_axi_awready;
  wire                  wFire    = s_axi_wvalid & s_axi_wready;
  wire                  haveAw   = awHeld | awFire;
  wire                  haveW    = wHeld | wFire;
  wire                  doWrite  = haveAw & haveW & ~s_axi_bvalid;
  wire [AXI_ADDR_W-1:0] curAw    = awHeld ? awAddr : s_axi_awaddr;
  wire [AXI_DATA_W-1:0] curW     = wHeld ? wData : s_axi_wdata;
  wire [3:0]            curStrb  = wHeld ? wStrb : s_axi_wstrb;
  wire [AXI_ADDR_W-1:0] wrWord   = {curAw[AXI_ADDR_W-1:2], 2'b00};
  wire                  wrCtrl   = doWrite & (wrWord == OFS_CTRL);
  wire                  wrFlags  = doWrite & (wrWord == OFS_FLAGS);
  wire                  wrCount  = doWrite & (wrWord == OFS_COUNT);
  wire                  wrMapped = wrCtrl | wrFlags | wrCount;

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (awFire) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (wFire) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- axi4-lite read path ----------------
  wire                  arFire = s_axi_arvalid & s_axi_arready;
  wire [AXI_ADDR_W-1:0] rdWord = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
  wire                  rdCtrl  = rdWord == OFS_CTRL;
  wire                  rdFlags = rdWord == OFS_FLAGS;
  wire                  rdCount = rdWord == OFS_COUNT;
  wire [AXI_DATA_W-1:0] rdMux =
      rdCtrl  ? {24'h000000, ctrl} :
      rdFlags ? {30'h00000000, flags} :
      rdCount ? {16'h0000, accumulatorCount} : '0;

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (arFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= (rdCtrl | rdFlags | rdCount) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- control register ----------------
  wire [7:0] next_ctrl = pac_merge(ctrl, curW[7:0] & CTRL_WMASK, curStrb[0]);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl <= next_ctrl;
    end
  end

  // ---------------- pin and accumulator clock ----------------
  pac_edge_sync u_edge_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pinIn     (channelSevenPin),
    .level     (pinLevel),
    .risePulse (pinRise),
    .fallPulse (pinFall)
  );

  wire accOn    = ctrl.accumulatorEnable;
  wire modeEv   = accOn & ~ctrl.gatedModeSelect;
  wire modeGate = accOn & ctrl.gatedModeSelect;
  wire edgeSel  = ctrl.edgePolaritySelect;
  // selected event edge
  wire evEdge   = edgeSel ? pinRise : pinFall;
  // gate open on high level for edge 0, low level for edge 1
  wire gateOpen = edgeSel ? ~pinLevel : pinLevel;
  // trailing edge of the gate
  wire gateEnd  = edgeSel ? pinRise : pinFall;
  // the div-64 tick only exists with the timer running
  wire tick64   = div64Tick & timerEnable;
  wire accClk   = (modeEv & evEdge) | (modeGate & gateOpen & tick64);
  wire edgeHit  = (modeEv & evEdge) | (modeGate & gateEnd);

  assign accumulatorClock = accClk;

  pac_clk_div u_clk_div (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tickIn    (accClk),
    .tick256   (tick256),
    .tick65536 (tick65536)
  );

  // main counter clock select, combinational so a write acts at once
  wire useSel = accOn;
  always_comb begin
    counterTick = prescalerTick;
    if (useSel) begin
      unique case (ctrl.clkSel)
        PAC_CLK_PRESCALER: counterTick = prescalerTick;
        PAC_CLK_ACC:       counterTick = accClk;
        PAC_CLK_ACC_256:   counterTick = tick256;
        PAC_CLK_ACC_64K:   counterTick = tick65536;
      endcase
    end
  end

  // ---------------- count and flags ----------------
  wire overflow = accClk & (accumulatorCount == COUNT_MAX) & ~wrCount;
  wire [15:0] next_count = {pac_merge(accumulatorCount[15:8], curW[15:8],
                                      curStrb[1]),
                            pac_merge(accumulatorCount[7:0], curW[7:0],
                                      curStrb[0])};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      accumulatorCount <= COUNT_RESET;
    end else if (wrCount) begin
      accumulatorCount <= next_count;
    end else if (accClk) begin
      accumulatorCount <= accumulatorCount + COUNT_STEP;
    end
  end

  // clears only while timer or accumulator runs; a set wins
  wire        clrOk     = wrFlags & curStrb[0] & (timerEnable | accOn);
  wire [1:0]  clrMask   = clrOk ? curW[1:0] : 2'b00;
  wire [1:0]  setMask   = {overflow, edgeHit};
  wire [1:0]  next_flag = (flags & ~clrMask) | setMask;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flag;
    end
  end

  assign overflowIrq  = flags.accumulatorOverflowFlag &
                        ctrl.overflowIrqEnable;
  assign inputEdgeIrq = flags.inputEdgeFlag & ctrl.inputEdgeIrqEnable;

  // ---------------- assertions ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence evFallSeen;
    modeEv & ~edgeSel & pinFall & ~wrCount & ~timerEnable;
  endsequence

  sequence gateHighTick;
    modeGate & ~edgeSel & pinLevel & div64Tick & timerEnable;
  endsequence

  sequence gateLowTick;
    modeGate & edgeSel & ~pinLevel & div64Tick & timerEnable;
  endsequence

  sequence accSelWritten;
    wrCtrl ##1 accOn & ctrl.clkSel == PAC_CLK_ACC;
  endsequence

  AST_INDEPENDENT: assert property (
    evFallSeen |=> accumulatorCount == $past(accumulatorCount) + COUNT_STEP)
    else $error("count did not advance with timer disabled");

  AST_PIN_PATH: assert property (
    modeEv & edgeSel & ~channelSevenPin ##1 channelSevenPin & modeEv &
    edgeSel ##1 modeEv & edgeSel [*2] |-> accClk)
    else $error("rising pin edge did not clock accumulator");

  AST_DISABLED_IDLE: assert property (
    !accOn |-> !accClk && !edgeHit)
    else $error("accumulator active while disabled");

  AST_RISE_COUNT: assert property (
    modeEv & edgeSel & pinRise & ~wrCount |=>
      accumulatorCount == $past(accumulatorCount) + COUNT_STEP)
    else $error("rising edge not counted");

  AST_GATE_HIGH: assert property (gateHighTick |-> accClk)
    else $error("high gate did not pass tick");

  AST_GATE_LOW: assert property (gateLowTick |-> accClk)
    else $error("low gate did not pass tick");

  AST_GATE_TRAIL: assert property (
    modeGate & ~edgeSel & pinFall |=> flags.inputEdgeFlag)
    else $error("trailing falling edge did not set edge flag");

  AST_NO_TICK: assert property (modeGate & ~timerEnable |-> !accClk)
    else $error("gated accumulation advanced with timer off");

  AST_DIV256: assert property (
    accOn & ctrl.clkSel == PAC_CLK_ACC_256 |-> counterTick == tick256)
    else $error("divide by 256 not selected");

  AST_PRESCALER: assert property (
    !accOn |-> counterTick == prescalerTick)
    else $error("main counter not on prescaler while disabled");

  AST_CTRL_WRITE: assert property (
    wrCtrl & curStrb[0] |=> ctrl == ($past(curW[7:0]) & CTRL_WMASK))
    else $error("control write not stored");

  AST_OVF_WRAP: assert property (
    overflow |=> flags.accumulatorOverflowFlag &&
      accumulatorCount == COUNT_RESET)
    else $error("wrap did not set overflow flag");

  AST_IRQ_OVF: assert property (
    overflow & ctrl.overflowIrqEnable & ~wrCtrl
      |=> overflowIrq)
    else $error("overflow request missing");

  AST_IRQ_EDGE: assert property (
    !ctrl.inputEdgeIrqEnable |-> !inputEdgeIrq)
    else $error("edge request not inhibited");

  AST_IRQ_OVF_OFF: assert property (
    !ctrl.overflowIrqEnable |-> !overflowIrq)
    else $error("overflow request not inhibited");

  AST_DIV64K: assert property (
    accOn & ctrl.clkSel == PAC_CLK_ACC_64K |-> counterTick == tick65536)
    else $error("divide by 65536 not selected");

  AST_SEL_AT_ONCE: assert property (
    accSelWritten |-> counterTick == accClk)
    else $error("new clock select not in effect after write");

  AST_EVENT_FLAG: assert property (
    modeEv & evEdge |=> flags.inputEdgeFlag)
    else $error("event edge did not set edge flag");

  AST_GATE_RISE_TRAIL: assert property (
    modeGate & edgeSel & pinRise |=> flags.inputEdgeFlag)
    else $error("trailing rising edge did not set edge flag");

  AST_GATE_SHUT: assert property (
    modeGate & ~edgeSel & ~pinLevel |-> !accClk)
    else $error("closed gate passed a tick");

  AST_CLR_REFUSED: assert property (
    wrFlags & ~timerEnable & ~accOn |=> flags == $past(flags))
    else $error("flag cleared while timer and accumulator off");

endmodule : pac_ctrl

// ===== rtl/pac_edge_sync.sv
// synchroniser and edge detector for the shared channel seven pin
`timescale 1ns/1ps
module pac_edge_sync
  import pac_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      risePulse,
  output logic      fallPulse
);

  logic syncA;
  logic syncB;
  logic prevB;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      prevB <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  assign level     = syncB;
  assign risePulse = syncB & ~prevB;
  assign fallPulse = ~syncB & prevB;

endmodule : pac_edge_sync

// ===== rtl/pac_pkg.sv
// package: register map, field layouts and constants of the accumulator
package pac_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  localparam logic [AXI_ADDR_W-1:0] OFS_CTRL  = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] OFS_FLAGS = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] OFS_COUNT = 8'h28;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_WMASK  = 8'h7F;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP  = 16'h0001;
  localparam logic [7:0]  DIV_LOW_MAX = 8'hFF;

  typedef enum logic [1:0] {
    PAC_CLK_PRESCALER = 2'b00,
    PAC_CLK_ACC       = 2'b01,
    PAC_CLK_ACC_256   = 2'b10,
    PAC_CLK_ACC_64K   = 2'b11
  } pac_clk_sel_t;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic         reserved;
    logic         accumulatorEnable;
    logic         gatedModeSelect;
    logic         edgePolaritySelect;
    pac_clk_sel_t clkSel;
    logic         overflowIrqEnable;
    logic         inputEdgeIrqEnable;
  } pac_ctrl_t;

  // flag register layout, bit 1 down to bit 0
  typedef struct packed {
    logic accumulatorOverflowFlag;
    logic inputEdgeFlag;
  } pac_flags_t;

  // byte lane merge under one strobe bit
  function automatic logic [7:0] pac_merge(input logic [7:0] oldVal,
                                           input logic [7:0] newVal,
                                           input logic       strobe);
    pac_merge = strobe ? newVal : oldVal;
  endfunction : pac_merge

endpackage : pac_pkg

// ===== verif/pac_pin_model.sv
// shared channel seven pin model: idle level plus bursts of pulses
`timescale 1ns/1ps
module pac_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       idleLevel,
  input  wire logic       burstReq,
  input  wire logic [9:0] burstLen,
  output logic            pinOut,
  output logic            burstBusy
);
  logic [9:0] left;
  logic [2:0] phase;

  initial burstBusy = 1'b0;

  // three cycles away from idle, three back, so every edge is seen apart
  assign pinOut = (burstBusy && phase < 3'h3) ? !idleLevel : idleLevel;

  always @(posedge ref_clk) begin
    if (!burstBusy) begin
      burstBusy <= burstReq;
      left      <= burstLen;
      phase     <= 3'h0;
    end else if (phase != 3'h5) begin
      phase <= phase + 3'h1;
    end else begin
      phase     <= 3'h0;
      left      <= left - 10'h1;
      burstBusy <= (left != 10'h1);
    end
  end
endmodule : pac_pin_model

// ===== verif/pulse_accumulator_control_tb_top.sv
// self-checking bench for the pulse accumulator control block
`timescale 1ns/1ps
module pulse_accumulator_control_tb_top;
  import pac_pkg::*;
  logic                  ref_clk, rst_n, timerEnable, presTick, div64Tick;
  logic [AXI_ADDR_W-1:0] awAddr, arAddr;
  logic [AXI_DATA_W-1:0] wData, rData;
  logic [3:0]            wStrb;
  logic [1:0]            bResp, rResp, presCnt;
  logic                  awValid, awReady, wValid, wReady, bValid, bReady;
  logic                  arValid, arReady, rValid, rReady, pin;
  logic                  counterTick, accClock, ovIrq, edgeIrq;
  logic                  idleLevel, burstReq, burstBusy;
  logic [9:0]            burstLen;
  int                    checks, fail_count, ctTicks, psTicks, acTicks;

  pac_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .channelSevenPin(pin),
    .timerEnable(timerEnable), .prescalerTick(presTick),
    .div64Tick(div64Tick), .counterTick(counterTick),
    .accumulatorClock(accClock), .overflowIrq(ovIrq),
    .inputEdgeIrq(edgeIrq));

  pac_pin_model pin_u (.ref_clk(ref_clk), .idleLevel(idleLevel),
    .burstReq(burstReq), .burstLen(burstLen), .pinOut(pin),
    .burstBusy(burstBusy));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // prescaler stand-in and pulse counters
  always @(posedge ref_clk) begin
    presCnt  <= presCnt + 2'h1;
    presTick <= (presCnt == 2'h3);
    ctTicks  <= ctTicks + (counterTick === 1'b1 ? 1 : 0);
    psTicks  <= psTicks + (presTick === 1'b1 ? 1 : 0);
    acTicks  <= acTicks + (accClock === 1'b1 ? 1 : 0);
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic hung;
    fail_count++;
    $display("mismatch wait expected answer seen none");
    print_verdict();
  endtask : hung

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int         n;
    logic       aw, w, b;
    logic [1:0] rb;
    n = 0;
    b = 1'b0;
    @(posedge ref_clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!b) begin
      @(negedge ref_clk);
      aw = awValid && awReady;
      w  = wValid && wReady;
      b  = bValid;
      rb = bResp;
      @(posedge ref_clk);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      if (b) bReady <= 1'b0;
      n++;
      if (n > 40) hung();
    end
    check("bresp", {30'h0, er}, {30'h0, rb});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int          n;
    logic        ar, r;
    logic [31:0] d;
    logic [1:0]  rr;
    n = 0;
    r = 1'b0;
    @(posedge ref_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    while (!r) begin
      @(negedge ref_clk);
      ar = arValid && arReady;
      r  = rValid;
      d  = rData;
      rr = rResp;
      @(posedge ref_clk);
      if (ar) arValid <= 1'b0;
      if (r) rReady <= 1'b0;
      n++;
      if (n > 40) hung();
    end
    check("rdata", ed, d);
    check("rresp", {30'h0, er}, {30'h0, rr});
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    axi_read(a, ed, RESP_OKAY);
  endtask : rd

  task automatic set_pin(input logic v);
    @(posedge ref_clk);
    idleLevel <= v;
    repeat (6) @(posedge ref_clk);
  endtask : set_pin

  task automatic set_ten(input logic v);
    @(posedge ref_clk);
    timerEnable <= v;
  endtask : set_ten

  task automatic pulses(input int k);
    int n;
    n = 0;
    @(posedge ref_clk);
    burstLen <= 10'(k);
    burstReq <= 1'b1;
    while (!burstBusy) begin
      @(posedge ref_clk);
      n++;
      if (n > 10) hung();
    end
    burstReq <= 1'b0;
    while (burstBusy) begin
      @(posedge ref_clk);
      n++;
      if (n > 2000) hung();
    end
    repeat (6) @(posedge ref_clk);
  endtask : pulses

  task automatic ticks(input int k);
    repeat (k) begin
      repeat (63) @(posedge ref_clk);
      div64Tick <= 1'b1;
      @(posedge ref_clk);
      div64Tick <= 1'b0;
    end
  endtask : ticks

  task automatic t_regs;
    check("irqs", 32'h0, {ovIrq, edgeIrq});
    rd(OFS_CTRL, 32'h0);
    axi_write(8'h30, 32'hFF, RESP_SLVERR);
    axi_read(8'h30, 32'h0, RESP_SLVERR);
    wr(OFS_CTRL, 32'hFF);
    rd(OFS_CTRL, 32'h7F);
    $display("test regs done");
  endtask : t_regs

  task automatic t_event;
    int a0;
    wr(OFS_CTRL, 32'h50);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_COUNT, 32'h0);
    a0 = acTicks;
    set_pin(1'b1);
    rd(OFS_COUNT, 32'h1);
    set_pin(1'b0);
    rd(OFS_COUNT, 32'h1);
    pulses(4);
    rd(OFS_COUNT, 32'h5);
    check("accClock", 32'h5, acTicks - a0);
    rd(OFS_FLAGS, 32'h1);
    check("edgeIrq", 32'h0, edgeIrq);
    wr(OFS_CTRL, 32'h51);
    check("edgeIrq", 32'h1, edgeIrq);
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_CTRL, 32'h40);
    set_pin(1'b1);
    rd(OFS_COUNT, 32'h5);
    set_pin(1'b0);
    rd(OFS_COUNT, 32'h6);
    $display("test event done");
  endtask : t_event

  task automatic t_clksel;
    int c0, p0;
    wr(OFS_CTRL, 32'h44);
    c0 = ctTicks;
    pulses(3);
    check("tick01", 32'h3, ctTicks - c0);
    wr(OFS_CTRL, 32'h48);
    c0 = ctTicks;
    pulses(256);
    check("tick256", 32'h1, ctTicks - c0);
    wr(OFS_CTRL, 32'h4C);
    c0 = ctTicks;
    pulses(4);
    check("tick64k", 32'h0, ctTicks - c0);
    wr(OFS_CTRL, 32'h40);
    c0 = ctTicks;
    p0 = psTicks;
    pulses(3);
    check("tick00", psTicks - p0, ctTicks - c0);
    wr(OFS_CTRL, 32'h0C);
    c0 = ctTicks;
    p0 = psTicks;
    pulses(3);
    check("tickoff", psTicks - p0, ctTicks - c0);
    rd(OFS_COUNT, 32'h110);
    $display("test clksel done");
  endtask : t_clksel

  task automatic t_over;
    wr(OFS_CTRL, 32'h42);
    wr(OFS_COUNT, 32'hFFFF);
    wr(OFS_FLAGS, 32'h3);
    pulses(1);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_FLAGS, 32'h3);
    check("ovIrq", 32'h1, ovIrq);
    wr(OFS_CTRL, 32'h40);
    check("ovIrq", 32'h0, ovIrq);
    wr(OFS_CTRL, 32'h00);
    wr(OFS_FLAGS, 32'h3);
    rd(OFS_FLAGS, 32'h3);
    set_ten(1'b1);
    wr(OFS_FLAGS, 32'h3);
    rd(OFS_FLAGS, 32'h0);
    $display("test overflow done");
  endtask : t_over

  task automatic t_gated;
    wr(OFS_CTRL, 32'h60);
    wr(OFS_COUNT, 32'h0);
    set_pin(1'b1);
    ticks(3);
    set_pin(1'b0);
    rd(OFS_COUNT, 32'h3);
    rd(OFS_FLAGS, 32'h1);
    set_ten(1'b0);
    set_pin(1'b1);
    ticks(3);
    set_pin(1'b0);
    rd(OFS_COUNT, 32'h3);
    wr(OFS_FLAGS, 32'h1);
    wr(OFS_CTRL, 32'h70);
    set_ten(1'b1);
    ticks(2);
    set_pin(1'b1);
    rd(OFS_COUNT, 32'h5);
    rd(OFS_FLAGS, 32'h1);
    $display("test gated done");
  endtask : t_gated

  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    {rst_n, timerEnable, presTick, div64Tick, presCnt} = '0;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    {awAddr, arAddr, wData, idleLevel, burstReq, burstLen} = '0;
    wStrb = 4'hF;
    {checks, fail_count, ctTicks, psTicks, acTicks} = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_event();
    t_clksel();
    t_over();
    t_gated();
    print_verdict();
  end
endmodule : pulse_accumulator_control_tb_top
